// ==== inc/vr_pkg.sv ====
// Purpose: shared constants and types for the voice recorder host-signal block
// Assumes: 40 MHz system clock, 16-bit serial words sent least significant bit first
// Notes:   play and record rows are counted in samples, so they scale with the selected rate; cue rows are counted in clock cycles
package vr_pkg;

   // clock and timing
   localparam int CLK_HZ          = 40_000_000;
   localparam int BASE_RATE_KHZ   = 8;
   localparam int ROW_MS          = 200;
   localparam int ROW_HIGH_MS     = 175;
   localparam int ROW_LOW_MS      = 25;
   localparam int SAMPLES_PER_ROW = ROW_MS * BASE_RATE_KHZ;
   localparam int ROW_LOW_SAMPLES = ROW_LOW_MS * BASE_RATE_KHZ;
   localparam int TRACK_SAMPLES   = 16;
   localparam int ROWS            = 1200;
   localparam int CUE_HIGH_NS     = 109_380;
   localparam int CUE_LOW_NS      = 15_630;
   localparam int CUE_HIGH_CYC    = CUE_HIGH_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int CUE_LOW_CYC     = CUE_LOW_NS * (CLK_HZ / 1_000_000) / 1000;
   localparam int DIV_8K0         = CLK_HZ / 8000;
   localparam int DIV_6K4         = CLK_HZ / 6400;
   localparam int DIV_5K3         = CLK_HZ * 3 / 16000;
   localparam int DIV_4K0         = CLK_HZ / 4000;
   localparam int EXT_POST_DIV    = 64;

   // serial word layout
   localparam int WORD_W   = 16;
   localparam int OP_LSB   = 0;
   localparam int OP_W     = 4;
   localparam int DATA_LSB = 4;
   localparam int DATA_W   = 12;
   localparam int ROW_W    = 11;

   // opcodes
   localparam logic [3:0] OP_NOP        = 4'h0;
   localparam logic [3:0] OP_READ_ALERT = 4'h1;
   localparam logic [3:0] OP_CONFIG     = 4'h2;
   localparam logic [3:0] OP_PLAY       = 4'h3;
   localparam logic [3:0] OP_RECORD     = 4'h4;
   localparam logic [3:0] OP_CUE        = 4'h5;
   localparam logic [3:0] OP_STOP       = 4'h6;

   // status word bit positions
   localparam int ST_FULL_BIT = 0;
   localparam int ST_END_BIT  = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_ROW_LSB  = 4;

   // configuration, carried in the data field of OP_CONFIG
   typedef struct packed {
      logic       ext_clk_sel;
      logic [1:0] line_route;
      logic       mic_to_agc;
      logic       line_gain_sel_hi;
      logic       line_gain_sel_lo;
      logic       rate_select_hi;
      logic       rate_select_lo;
   } vr_cfg_s;

   localparam int CFG_W = 8;
   localparam vr_cfg_s CFG_RESET = '0;

   typedef enum logic [1:0] {
      LINE_TO_NONE,
      LINE_TO_SPEAKER,
      LINE_TO_ARRAY,
      LINE_TO_OTHER
   } vr_line_route_e;

endpackage

// ==== hw/vr_tick_div.sv ====
// Purpose: counts enable pulses and emits one tick every i_div of them
// Assumes: i_div is at least one
// Notes:   a change of i_div takes effect at once; a count already at or past the new limit wraps on the next enable
`timescale 1ns/1ps
module vr_tick_div #(
   parameter int W = 14
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // control
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_div,
   // tick out
   output logic              o_tick
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q  <= '0;
         o_tick <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (i_en) begin
            if (cnt_q >= i_div - W'(1)) begin
               cnt_q  <= '0;
               o_tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + W'(1);
            end
         end
      end
   end

endmodule // vr_tick_div

// ==== hw/vr_serial.sv ====
// Purpose: serial slave shifter, 16-bit words least significant bit first
// Assumes: serial pins are synchronous to i_clk and slower than it
// Notes:   a word counts only when exactly 16 bits arrive while selected
`timescale 1ns/1ps
module vr_serial
   import vr_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // serial pins
   input  wire logic              i_sclk,
   input  wire logic              i_ss_n,
   input  wire logic              i_mosi,
   output logic                   o_miso,
   output logic                   o_miso_oe,
   // word side
   input  wire logic [WORD_W-1:0] i_tx_word,
   output logic [WORD_W-1:0]      o_rx_word,
   output logic                   o_rx_valid
);

   logic              sclk_q;
   logic              ss_n_q;
   logic [WORD_W-1:0] rx_q;
   logic [WORD_W-1:0] tx_q;
   logic [4:0]        cnt_q;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              sel_start;
   logic              sel_end;

   assign sclk_rise = i_sclk & ~sclk_q & ~i_ss_n;
   assign sclk_fall = ~i_sclk & sclk_q & ~i_ss_n;
   assign sel_start = ~i_ss_n & ss_n_q;
   assign sel_end   = i_ss_n & ~ss_n_q;
   assign o_miso_oe = ~i_ss_n;
   assign o_miso    = tx_q[0];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_q <= 1'b0;
         ss_n_q <= 1'b1;
      end else begin
         sclk_q <= i_sclk;
         ss_n_q <= i_ss_n;
      end
   end

   // receive on rising edge, lsb first
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_q  <= '0;
         cnt_q <= '0;
      end else if (sel_start) begin
         cnt_q <= '0;
      end else if (sclk_rise) begin
         rx_q <= {i_mosi, rx_q[WORD_W-1:1]};
         if (cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   // transmit on falling edge, lsb first
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_q <= '0;
      end else if (sel_start) begin
         tx_q <= i_tx_word;
      end else if (sclk_fall) begin
         tx_q <= {1'b0, tx_q[WORD_W-1:1]};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_word  <= '0;
         o_rx_valid <= 1'b0;
      end else begin
         o_rx_valid <= sel_end && (cnt_q == 5'(WORD_W));
         if (sel_end) begin
            o_rx_word <= rx_q;
         end
      end
   end

endmodule // vr_serial

// ==== hw/vr_host_signals.sv ====
// Purpose: host-facing digital logic of a serial-controlled voice recorder
// Assumes: all pins synchronous to i_clk; analog array reports end markers on i_marker_found
// Notes:   open-drain pins only ever pull low; external clock pull-down sits in the pad
`timescale 1ns/1ps

module vr_host_signals
   import vr_pkg::*;
#(
   parameter int CUE_HIGH_CYCLES = CUE_HIGH_CYC,
   parameter int CUE_LOW_CYCLES  = CUE_LOW_CYC,
   parameter int DIV_8K          = DIV_8K0,
   parameter int DIV_6K          = DIV_6K4,
   parameter int DIV_5K          = DIV_5K3,
   parameter int DIV_4K          = DIV_4K0,
   parameter int SAMPLES_ROW     = SAMPLES_PER_ROW,
   parameter int LOW_SAMPLES     = ROW_LOW_SAMPLES,
   parameter int TRACK_LEN       = TRACK_SAMPLES,
   parameter int NUM_ROWS        = ROWS
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // serial port
   input  wire logic             i_sclk,
   input  wire logic             i_ss_n,
   input  wire logic             i_mosi,
   output logic                  o_miso,
   output logic                  o_miso_oe,
   // alert, open drain
   output logic                  o_alert_out,
   output logic                  o_alert_oe,
   // row boundary strobe, open drain
   output logic                  o_row_strobe_out,
   output logic                  o_row_strobe_oe,
   // sample clock and array
   input  wire logic             i_ext_sample_clock_in,
   input  wire logic             i_marker_found,
   output logic                  o_sample_tick,
   // analog path settings
   output vr_cfg_s               o_cfg,
   output logic [1:0]            o_filter_band,
   // operation status
   output logic                  o_play_active,
   output logic                  o_rec_active,
   output logic                  o_cue_active,
   output logic [ROW_W-1:0]      o_row_addr,
   output logic                  o_memory_full_flag,
   output logic                  o_message_end_flag
);

   typedef enum logic [1:0] {
      VR_IDLE,
      VR_PLAY,
      VR_REC,
      VR_CUE
   } vr_op_e;

   localparam int DIV_W = 14;
   localparam int SMP_W = 12;
   localparam int CUE_W = 13;

   function automatic logic [DIV_W-1:0] rate_div(input logic [1:0] code);
      case (code)
         2'h0:    rate_div = DIV_W'(DIV_8K);
         2'h1:    rate_div = DIV_W'(DIV_6K);
         2'h2:    rate_div = DIV_W'(DIV_5K);
         default: rate_div = DIV_W'(DIV_4K);
      endcase
   endfunction

   vr_op_e              op_q;
   vr_cfg_s             cfg_q;
   logic [ROW_W-1:0]    row_q;
   logic [SMP_W-1:0]    smp_q;
   logic [CUE_W-1:0]    cue_q;
   logic                first_row_q;
   logic                full_q;
   logic                end_q;
   logic                alert_q;
   logic                strobe_low_q;
   logic                ext_q;
   logic                ext_half_q;
   logic                ext_half_d;
   logic                ext_en;
   logic                int_tick;
   logic                ext_tick;
   logic                tick;
   logic [WORD_W-1:0]   rx_word;
   logic                rx_valid;
   logic [WORD_W-1:0]   tx_word;
   logic [OP_W-1:0]     opcode;
   logic [DATA_W-1:0]   data;
   logic [1:0]          rate_code;
   logic [SMP_W-1:0]    row_len;
   logic                row_end;
   logic                last_row;
   logic                full_evt;
   logic                end_evt;
   logic                strobe_low_d;

   assign opcode    = rx_word[OP_LSB +: OP_W];
   assign data      = rx_word[DATA_LSB +: DATA_W];
   assign rate_code = {cfg_q.rate_select_hi, cfg_q.rate_select_lo};

   // serial slave
   always_comb begin
      tx_word                           = '0;
      tx_word[ST_FULL_BIT]              = full_q;
      tx_word[ST_END_BIT]               = end_q;
      tx_word[ST_BUSY_BIT]              = (op_q != VR_IDLE);
      tx_word[ST_ROW_LSB +: ROW_W]      = row_q;
   end

   vr_serial u_serial (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_sclk     (i_sclk),
      .i_ss_n     (i_ss_n),
      .i_mosi     (i_mosi),
      .o_miso     (o_miso),
      .o_miso_oe  (o_miso_oe),
      .i_tx_word  (tx_word),
      .o_rx_word  (rx_word),
      .o_rx_valid (rx_valid)
   );

   // external clock halved on entry
   assign ext_half_d = ext_half_q ^ (i_ext_sample_clock_in & ~ext_q);
   assign ext_en     = ext_half_d & ~ext_half_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_q      <= 1'b0;
         ext_half_q <= 1'b0;
      end else begin
         ext_q      <= i_ext_sample_clock_in;
         ext_half_q <= ext_half_d;
      end
   end

   vr_tick_div #(.W(DIV_W)) u_int_div (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_en    (1'b1),
      .i_div   (rate_div(rate_code)),
      .o_tick  (int_tick)
   );

   vr_tick_div #(.W(DIV_W)) u_ext_div (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_en    (ext_en),
      .i_div   (DIV_W'(EXT_POST_DIV)),
      .o_tick  (ext_tick)
   );

   assign tick          = cfg_q.ext_clk_sel ? ext_tick : int_tick;
   assign o_sample_tick = tick;

   // configuration
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= CFG_RESET;
      end else if (rx_valid && opcode == OP_CONFIG) begin
         cfg_q <= vr_cfg_s'(data[CFG_W-1:0]);
      end
   end

   assign o_cfg         = cfg_q;
   assign o_filter_band = rate_code;

   // row progress
   assign row_len  = first_row_q ? SMP_W'(SAMPLES_ROW + TRACK_LEN) : SMP_W'(SAMPLES_ROW);
   assign last_row = (row_q == ROW_W'(NUM_ROWS - 1));

   always_comb begin
      row_end = 1'b0;
      case (op_q)
         VR_PLAY, VR_REC: row_end = tick && (smp_q == row_len - SMP_W'(1));
         VR_CUE:          row_end = (cue_q == CUE_W'(CUE_HIGH_CYCLES + CUE_LOW_CYCLES - 1));
         default:         row_end = 1'b0;
      endcase
   end

   assign full_evt = row_end && last_row;
   assign end_evt  = i_marker_found && (op_q == VR_PLAY || op_q == VR_CUE);

   // operation state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         op_q <= VR_IDLE;
      end else if (rx_valid) begin
         case (opcode)
            OP_PLAY:   op_q <= VR_PLAY;
            OP_RECORD: op_q <= VR_REC;
            OP_CUE:    op_q <= VR_CUE;
            OP_STOP:   op_q <= VR_IDLE;
            default:   op_q <= op_q;
         endcase
      end else if (full_evt || end_evt) begin
         op_q <= VR_IDLE;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         row_q <= '0;
      end else if (rx_valid && (opcode == OP_PLAY || opcode == OP_RECORD || opcode == OP_CUE)) begin
         row_q <= data[ROW_W-1:0];
      end else if (row_end && !last_row) begin
         row_q <= row_q + ROW_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         smp_q <= '0;
      end else if (rx_valid || op_q == VR_IDLE || op_q == VR_CUE) begin
         smp_q <= '0;
      end else if (tick) begin
         smp_q <= row_end ? '0 : smp_q + SMP_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cue_q <= '0;
      end else if (rx_valid || op_q != VR_CUE || row_end) begin
         cue_q <= '0;
      end else begin
         cue_q <= cue_q + CUE_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_row_q <= 1'b0;
      end else if (rx_valid && opcode == OP_RECORD) begin
         first_row_q <= 1'b1;
      end else if (row_end || op_q == VR_IDLE) begin
         first_row_q <= 1'b0;
      end
   end

   // row strobe
   always_comb begin
      case (op_q)
         VR_PLAY, VR_REC: strobe_low_d = (smp_q >= row_len - SMP_W'(LOW_SAMPLES));
         VR_CUE:          strobe_low_d = (cue_q >= CUE_W'(CUE_HIGH_CYCLES));
         default:         strobe_low_d = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strobe_low_q <= 1'b0;
      end else begin
         strobe_low_q <= strobe_low_d && !rx_valid;
      end
   end

   assign o_row_strobe_out = 1'b0;
   assign o_row_strobe_oe  = strobe_low_q;

   // flags and alert; a new event wins over the clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         full_q <= 1'b0;
      end else if (full_evt) begin
         full_q <= 1'b1;
      end else if (rx_valid) begin
         full_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         end_q <= 1'b0;
      end else if (end_evt) begin
         end_q <= 1'b1;
      end else if (rx_valid) begin
         end_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alert_q <= 1'b0;
      end else if (full_evt || end_evt) begin
         alert_q <= 1'b1;
      end else if (rx_valid) begin
         alert_q <= 1'b0;
      end
   end

   assign o_alert_out = 1'b0;
   assign o_alert_oe  = alert_q;

   // status outputs
   assign o_play_active      = (op_q == VR_PLAY);
   assign o_rec_active       = (op_q == VR_REC);
   assign o_cue_active       = (op_q == VR_CUE);
   assign o_row_addr         = row_q;
   assign o_memory_full_flag = full_q;
   assign o_message_end_flag = end_q;

endmodule // vr_host_signals

// ==== sim/vrt_checker.sv ====
// Purpose: port checker for the host-signal block
// Assumes: single clock domain
// Notes:   bound to the top design module
`timescale 1ns/1ps
module vrt_checker
   import vr_pkg::*;
#(
   parameter int CUE_HIGH_CYCLES = CUE_HIGH_CYC,
   parameter int CUE_LOW_CYCLES  = CUE_LOW_CYC
) (
   // clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   // watched pins
   input wire logic       i_sclk,
   input wire logic       i_ss_n,
   input wire logic       o_miso,
   input wire logic       o_miso_oe,
   input wire logic       o_alert_out,
   input wire logic       o_alert_oe,
   input wire logic       o_row_strobe_out,
   input wire logic       o_row_strobe_oe,
   input wire vr_cfg_s    o_cfg,
   input wire logic [1:0] o_filter_band,
   input wire logic       o_play_active,
   input wire logic       o_cue_active,
   input wire logic       o_memory_full_flag,
   input wire logic       o_message_end_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   logic [15:0] run_q;
   logic        seen_q;

   // cycles spent at the current strobe level
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_q  <= 16'h0001;
         seen_q <= 1'b0;
      end else begin
         run_q  <= $changed(o_row_strobe_oe) ? 16'h0001 : run_q + 16'h0001;
         seen_q <= o_cue_active && (seen_q || $changed(o_row_strobe_oe));
      end
   end

   miso_float_a: assert property (o_miso_oe == !i_ss_n)
      else $error("miso enable does not follow select");
   od_low_a: assert property (!o_alert_out && !o_row_strobe_out)
      else $error("open drain pin driven high");
   alert_set_a: assert property (
      $rose(o_memory_full_flag) || $rose(o_message_end_flag) |-> o_alert_oe)
      else $error("flag set without alert");
   alert_hold_a: assert property (o_alert_oe && i_ss_n && $past(i_ss_n) &&
      $past(i_ss_n, 2) && $past(i_ss_n, 3) && $past(i_ss_n, 4) |=> o_alert_oe)
      else $error("alert dropped without transaction");
   alert_clear_a: assert property ($fell(o_alert_oe) |-> i_ss_n &&
      (!$past(i_ss_n, 2) || !$past(i_ss_n, 3) || !$past(i_ss_n, 4)))
      else $error("alert cleared outside transaction end");
   end_play_a: assert property ($rose(o_message_end_flag) |->
      $past(o_play_active) || $past(o_cue_active))
      else $error("end flag outside playback");
   band_track_a: assert property ($stable(o_cfg) |->
      o_filter_band == {o_cfg.rate_select_hi, o_cfg.rate_select_lo})
      else $error("filter band differs from rate code");
   cue_timing_a: assert property ($changed(o_row_strobe_oe) && o_cue_active && seen_q |->
      run_q == (o_row_strobe_oe ? CUE_HIGH_CYCLES : CUE_LOW_CYCLES))
      else $error("cue strobe level length wrong");
   miso_edge_a: assert property (!i_ss_n && !$past(i_ss_n) && $changed(o_miso) |-> !i_sclk)
      else $error("miso changed with serial clock high");
endmodule // vrt_checker

bind vr_host_signals vrt_checker #(
   .CUE_HIGH_CYCLES(CUE_HIGH_CYCLES),
   .CUE_LOW_CYCLES(CUE_LOW_CYCLES)
) u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_ss_n(i_ss_n),
   .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_alert_out(o_alert_out),
   .o_alert_oe(o_alert_oe), .o_row_strobe_out(o_row_strobe_out),
   .o_row_strobe_oe(o_row_strobe_oe), .o_cfg(o_cfg), .o_filter_band(o_filter_band),
   .o_play_active(o_play_active), .o_cue_active(o_cue_active),
   .o_memory_full_flag(o_memory_full_flag), .o_message_end_flag(o_message_end_flag)
);

// ==== sim/vrt_master.sv ====
// Purpose: serial master model
// Assumes: 8 clock cycles per serial bit
// Notes:   serial clock idles low outside frames
`timescale 1ns/1ps
module vrt_master (
   // clock
   input  wire logic  i_clk,
   // serial pins
   input  wire logic  i_miso,
   output logic       o_sclk,
   output logic       o_ss_n,
   output logic       o_mosi,
   // received word
   output logic [15:0] o_rx,
   output logic        o_rx_done
);
   initial begin
      o_sclk    = 1'b0;
      o_ss_n    = 1'b1;
      o_mosi    = 1'b0;
      o_rx      = 16'h0000;
      o_rx_done = 1'b0;
   end

   task automatic xfer(input logic [15:0] w, input int n);
      logic [15:0] r;
      r = 16'h0000;
      @(posedge i_clk);
      o_ss_n <= 1'b0;
      o_mosi <= w[0];
      repeat (4) @(posedge i_clk);
      for (int i = 0; i < n; i++) begin
         o_sclk <= 1'b1;
         r[i] = i_miso;
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b0;
         o_mosi <= w[(i + 1) % 16];
         repeat (4) @(posedge i_clk);
      end
      o_ss_n    <= 1'b1;
      o_mosi    <= ~o_mosi;
      o_rx      <= r;
      o_rx_done <= (n == 16);
      @(posedge i_clk);
      o_rx_done <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
endmodule // vrt_master

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the host-signal block
// Assumes: shortened row and divider parameters
// Notes:   status words checked through a queue
`timescale 1ns/1ps
module tb_top;
   import vr_pkg::*;
   localparam int DIVS [4] = '{8, 10, 12, 16};
   localparam int SROW = 16;
   localparam int LOWS = 2;
   localparam int TRK  = 2;
   localparam int CHI  = 7;
   localparam int CLO  = 1;
   localparam int NROW = 4;

   logic        i_clk, i_rst_n, marker, sclk, ss_n, mosi, miso, miso_oe;
   logic        ext_clk = 1'b0;
   logic [1:0]  ext_ph = 2'h0;
   logic        alert_out, alert_oe, rs_out, rs_oe, tick, play, rec, cue, full, endf;
   logic        rx_done, ext_en;
   logic [1:0]  band;
   logic [10:0] row;
   logic [15:0] rx, rnd;
   logic [15:0] exp_q[$];
   logic [15:0] mask_q[$];
   vr_cfg_s     cfg, c;
   int          fails, checked, cyc, lo, hi, t;

   vr_host_signals #(.CUE_HIGH_CYCLES(CHI), .CUE_LOW_CYCLES(CLO), .DIV_8K(DIVS[0]),
      .DIV_6K(DIVS[1]), .DIV_5K(DIVS[2]), .DIV_4K(DIVS[3]), .SAMPLES_ROW(SROW),
      .LOW_SAMPLES(LOWS), .TRACK_LEN(TRK), .NUM_ROWS(NROW)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_ss_n(ss_n), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe(miso_oe), .o_alert_out(alert_out), .o_alert_oe(alert_oe),
      .o_row_strobe_out(rs_out), .o_row_strobe_oe(rs_oe), .i_ext_sample_clock_in(ext_clk),
      .i_marker_found(marker), .o_sample_tick(tick), .o_cfg(cfg), .o_filter_band(band),
      .o_play_active(play), .o_rec_active(rec), .o_cue_active(cue), .o_row_addr(row),
      .o_memory_full_flag(full), .o_message_end_flag(endf));

   // released data line reads inverted, so a missing enable shows up
   vrt_master u_mst (.i_clk(i_clk), .i_miso(miso_oe ? miso : ~miso), .o_sclk(sclk),
      .o_ss_n(ss_n), .o_mosi(mosi), .o_rx(rx), .o_rx_done(rx_done));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [3:0] op, input logic [11:0] d, input logic [15:0] e);
      exp_q.push_back(e);
      mask_q.push_back(16'h0003);
      u_mst.xfer({d, op}, 16);
   endtask

   task automatic pulse_marker();
      marker <= 1'b1;
      @(posedge i_clk);
      marker <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask

   task automatic measure(output int l, output int h);
      l = 0;
      h = 0;
      while (!rs_oe) @(posedge i_clk);
      while (rs_oe) begin
         @(posedge i_clk);
         l++;
      end
      while (!rs_oe) begin
         @(posedge i_clk);
         h++;
      end
   endtask

   task automatic tick_gap(output int n);
      n = 0;
      while (!tick) @(posedge i_clk);
      do begin
         @(posedge i_clk);
         n++;
      end while (!tick);
   endtask

   task automatic wait_full();
      for (int i = 0; i < 1500 && full !== 1'b1; i++) @(posedge i_clk);
   endtask

   // status monitor
   always @(posedge i_clk) begin
      if (rx_done && exp_q.size() > 0) begin
         chk(rx & mask_q[0], exp_q[0] & mask_q[0]);
         void'(exp_q.pop_front());
         void'(mask_q.pop_front());
      end
   end

   // uneven duty external clock, three cycles a period
   always @(posedge i_clk) begin
      ext_ph  <= (ext_ph == 2'h2) ? 2'h0 : ext_ph + 2'h1;
      ext_clk <= ext_en && (ext_ph == 2'h0);
   end

   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      i_rst_n = 1'b0;
      marker  = 1'b0;
      ext_en  = 1'b0;
      rnd     = 16'hb79e;
      fails   = 0;
      checked = 0;
      cyc     = 0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk({alert_oe, rs_oe, play, rec, cue, full, endf}, 16'h0000);
      chk(cfg, CFG_RESET);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         c = {1'b0, rnd[2:0], i[2:1], i[1:0]};
         send(OP_CONFIG, {4'h0, c}, 16'h0000);
         chk(cfg, c);
         chk(band, i[1:0]);
      end
      for (int r = 0; r < 4; r++) begin
         send(OP_CONFIG, {10'h000, r[1:0]}, 16'h0000);
         send(OP_PLAY, 12'h000, 16'h0000);
         measure(lo, hi);
         chk(lo, LOWS * DIVS[r]);
         chk(hi, (SROW - LOWS) * DIVS[r]);
         tick_gap(t);
         chk(t, DIVS[r]);
         send(OP_STOP, 12'h000, 16'h0000);
      end
      send(OP_PLAY, 12'h000, 16'h0000);
      repeat (20) @(posedge i_clk);
      pulse_marker();
      chk({endf, full, alert_oe, play}, 16'h000a);
      u_mst.xfer(16'h00ff, 8);
      chk(alert_oe, 1'b1);
      send(OP_READ_ALERT, 12'h000, 16'h0002);
      chk(alert_oe, 1'b0);
      send(OP_CONFIG, 12'h000, 16'h0000);
      send(OP_RECORD, 12'h000, 16'h0000);
      t = 0;
      while (!rs_oe) begin
         @(posedge i_clk);
         t++;
      end
      chk(t > (SROW - LOWS) * 8 + 8 && t <= (SROW - LOWS + TRK) * 8, 1'b1);
      pulse_marker();
      wait_full();
      chk({endf, full, alert_oe, rec}, 16'h0006);
      chk(row, NROW - 1);
      send(OP_READ_ALERT, 12'h000, 16'h0001);
      send(OP_CUE, 12'h000, 16'h0000);
      wait_full();
      repeat (2) @(posedge i_clk);
      chk({full, alert_oe, cue}, 16'h0006);
      chk(row, NROW - 1);
      send(OP_NOP, 12'h000, 16'h0001);
      ext_en <= 1'b1;
      send(OP_CONFIG, 12'h080, 16'h0000);
      send(OP_PLAY, 12'h000, 16'h0000);
      tick_gap(t);
      tick_gap(t);
      chk(t, 2 * EXT_POST_DIV * 3);
      send(OP_STOP, 12'h000, 16'h0000);
      report_and_stop();
   end
endmodule // tb_top
